// ### rtl/sltcr_cfg.svh
`ifndef SLTCR_CFG_SVH
`define SLTCR_CFG_SVH

// register indices; byte address is four times the index
`define SLTCR_IDX_SER_POL       16'h0706
`define SLTCR_IDX_ASYNC_SER     16'h070A
`define SLTCR_IDX_LINK_RST      16'h0710
`define SLTCR_IDX_MODE_CHECK    16'h0711
`define SLTCR_IDX_QS_OVERRIDE   16'h0712
`define SLTCR_IDX_PHASE_STAT    16'h0713
`define SLTCR_IDX_LANE_DIV      16'h0717
`define SLTCR_IDX_LINK_PAGE     16'h0718

// field positions
`define SLTCR_BIT_SER_POL       0
`define SLTCR_BIT_LOOP2_INV     4
`define SLTCR_BIT_LOOP1_INV     5
`define SLTCR_BIT_ASYNC_SER     0
`define SLTCR_BIT_FORCE_RST     0
`define SLTCR_BIT_DIG_RST       4
`define SLTCR_BIT_BAD_MODE      0
`define SLTCR_BIT_QS_OVERRIDE   0
`define SLTCR_BIT_PHASE         0
`define SLTCR_BIT_PAGE          0
`define SLTCR_DIV_MSB           1
`define SLTCR_DIV_LSB           0

// reset values
`define SLTCR_RST_SER_POL       1'h0
`define SLTCR_RST_LOOP_INV      1'h0
`define SLTCR_RST_ASYNC_SER     1'h0
`define SLTCR_RST_FORCE_RST     1'h1
`define SLTCR_RST_DIG_RST       1'h0
`define SLTCR_RST_QS_OVERRIDE   1'h0
`define SLTCR_RST_LANE_DIV      2'h2
`define SLTCR_RST_PAGE          1'h0

`endif

// ### rtl/sltcr_pkg.sv
package sltcr_pkg;

    typedef struct packed {
        logic loop1_lane_clock_inv;
        logic loop2_link_clock_inv;
        logic serial_clock_polarity;
    } sltcr_clk_ctrl_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } sltcr_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } sltcr_apb_rsp_t;

endpackage

// ### rtl/sltcr_clk_path.sv
`timescale 1ns/1ps
`include "sltcr_cfg.svh"

module sltcr_clk_path
    import sltcr_pkg::*;
(
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // control
    input  wire sltcr_clk_ctrl_t ctrl,
    input  wire logic [1:0]      div_sel,
    // clocks in
    input  wire logic            ser_clk,
    input  wire logic            lane_clk,
    input  wire logic            link_clk,
    // clocks out
    output logic                 ser_clk_dout,
    output logic                 lane_clk_loop1,
    output logic                 link_clk_loop2,
    output logic                 rate_strobe
);

    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic [2:0] limit;
    logic       strobe_q;

    ////////////////////////////////////////////////////////////////////////////
    // polarity selection
    assign ser_clk_dout   = ser_clk ^ ctrl.serial_clock_polarity;
    assign lane_clk_loop1 = lane_clk ^ ctrl.loop1_lane_clock_inv;
    assign link_clk_loop2 = link_clk ^ ctrl.loop2_link_clock_inv;

    ////////////////////////////////////////////////////////////////////////////
    // rate divider: code n divides by two to the n
    always_comb
    begin
        limit = 3'((4'h1 << div_sel) - 4'h1);
        cnt_d = (cnt_q >= limit) ? 3'h0 : 3'(cnt_q + 3'h1);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q    <= 3'h0;
            strobe_q <= 1'h0;
        end
        else
        begin
            cnt_q    <= cnt_d;
            strobe_q <= (cnt_q >= limit);
        end
    end

    assign rate_strobe = strobe_q;

endmodule

// ### rtl/sltcr_regs.sv
// How it works
// - serial clock polarity bit inverts output clock
// - bit 5 inverts loopback 1 lane clock
// - bit 4 inverts loopback 2 link clock
// - bit 4 holds link in digital reset
// - forced link reset defaults one, per page
// - override bit swaps in programmed frame values
// - divider field: 0 undivided, 1 halves; resets 2
// - divider field mirrors PLL-space divider setting
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "sltcr_cfg.svh"

module sltcr_regs
    import sltcr_pkg::*;
#(
    parameter int FRAME_W = 16
)
(
    // clock and reset
    input  wire logic               CORE_CLK,
    input  wire logic               RESET,
    // apb slave
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    input  wire logic [15:0]        PADDR,
    input  wire logic [31:0]        PWDATA,
    output logic                    PREADY,
    output logic                    PSLVERR,
    output logic [31:0]             PRDATA,
    // pll register space mirror
    input  wire logic               PLL_DIV_WE,
    input  wire logic [1:0]         PLL_DIV_WDATA,
    output logic [1:0]              PLL_DIV_MIRROR,
    // link status
    input  wire logic [1:0]         BAD_MODE_IN,
    input  wire logic [1:0]         PHASE_ALIGNED_IN,
    // frame values
    input  wire logic [FRAME_W-1:0] QS_FRAME_VAL,
    input  wire logic [FRAME_W-1:0] PROG_FRAME_VAL,
    output logic [FRAME_W-1:0]      FRAME_VAL,
    // link controls
    output logic [1:0]              LINK_RESET,
    output logic [1:0]              LINK_DIG_RESET,
    output logic                    ASYNC_SER_MODE,
    output logic [1:0]              LANE_DIV_SEL,
    // clocks
    input  wire logic               SER_CLK_IN,
    input  wire logic               LANE_CLK_IN,
    input  wire logic               LINK_CLK_IN,
    output logic                    SER_CLK_DOUT,
    output logic                    LANE_CLK_LOOP1,
    output logic                    LINK_CLK_LOOP2,
    output logic                    LANE_RATE_STROBE
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic hit(input logic [15:0] addr, input logic [15:0] idx);
        logic [17:0] byte_addr;
        byte_addr = {idx, 2'b00};
        hit       = (addr == byte_addr[15:0]);
    endfunction

    function automatic logic mapped(input logic [15:0] addr);
        mapped = hit(addr, `SLTCR_IDX_SER_POL)
               | hit(addr, `SLTCR_IDX_ASYNC_SER)
               | hit(addr, `SLTCR_IDX_LINK_RST)
               | hit(addr, `SLTCR_IDX_MODE_CHECK)
               | hit(addr, `SLTCR_IDX_QS_OVERRIDE)
               | hit(addr, `SLTCR_IDX_PHASE_STAT)
               | hit(addr, `SLTCR_IDX_LANE_DIV)
               | hit(addr, `SLTCR_IDX_LINK_PAGE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus request

    sltcr_apb_req_t  req;
    sltcr_apb_rsp_t  rsp;
    sltcr_clk_ctrl_t clk_ctrl;

    logic            setup;
    logic            access;
    logic            wr_en;
    logic [7:0]      wbyte;

    assign req.psel    = PSEL;
    assign req.penable = PENABLE;
    assign req.pwrite  = PWRITE;
    assign req.paddr   = PADDR;
    assign req.pwdata  = PWDATA;

    assign setup  = req.psel & ~req.penable;
    assign access = req.psel & req.penable;
    assign wr_en  = access & req.pwrite;
    assign wbyte  = req.pwdata[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // register state

    logic       ser_pol_q;
    logic       loop1_inv_q;
    logic       loop2_inv_q;
    logic       async_q;
    logic       page_q;
    logic [1:0] force_rst_q;
    logic [1:0] dig_rst_q;
    logic       override_q;
    logic [1:0] div_q;
    logic [1:0] div_d;
    logic [FRAME_W-1:0] frame_q;
    logic [31:0] rdata_q;
    logic [7:0]  rbyte;

    ////////////////////////////////////////////////////////////////////////////
    // clock polarity register

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ser_pol_q   <= `SLTCR_RST_SER_POL;
            loop1_inv_q <= `SLTCR_RST_LOOP_INV;
            loop2_inv_q <= `SLTCR_RST_LOOP_INV;
        end
        else if (wr_en && hit(req.paddr, `SLTCR_IDX_SER_POL))
        begin
            ser_pol_q   <= wbyte[`SLTCR_BIT_SER_POL];
            loop1_inv_q <= wbyte[`SLTCR_BIT_LOOP1_INV];
            loop2_inv_q <= wbyte[`SLTCR_BIT_LOOP2_INV];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // async serializer setting

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            async_q <= `SLTCR_RST_ASYNC_SER;
        end
        else if (wr_en && hit(req.paddr, `SLTCR_IDX_ASYNC_SER))
        begin
            async_q <= wbyte[`SLTCR_BIT_ASYNC_SER];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link page select

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            page_q <= `SLTCR_RST_PAGE;
        end
        else if (wr_en && hit(req.paddr, `SLTCR_IDX_LINK_PAGE))
        begin
            page_q <= wbyte[`SLTCR_BIT_PAGE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-link resets, steered by the page

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            force_rst_q <= {2{`SLTCR_RST_FORCE_RST}};
            dig_rst_q   <= {2{`SLTCR_RST_DIG_RST}};
        end
        else if (wr_en && hit(req.paddr, `SLTCR_IDX_LINK_RST))
        begin
            force_rst_q[page_q] <= wbyte[`SLTCR_BIT_FORCE_RST];
            dig_rst_q[page_q]   <= wbyte[`SLTCR_BIT_DIG_RST];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // quick setup override and frame value select

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            override_q <= `SLTCR_RST_QS_OVERRIDE;
        end
        else if (wr_en && hit(req.paddr, `SLTCR_IDX_QS_OVERRIDE))
        begin
            override_q <= wbyte[`SLTCR_BIT_QS_OVERRIDE];
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            frame_q <= '0;
        end
        else
        begin
            frame_q <= override_q ? PROG_FRAME_VAL : QS_FRAME_VAL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lane-rate divider, shared with the pll register space

    always_comb
    begin
        div_d = div_q;
        if (PLL_DIV_WE)
        begin
            div_d = PLL_DIV_WDATA;
        end
        if (wr_en && hit(req.paddr, `SLTCR_IDX_LANE_DIV))
        begin
            div_d = wbyte[`SLTCR_DIV_MSB:`SLTCR_DIV_LSB];
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            div_q <= `SLTCR_RST_LANE_DIV;
        end
        else
        begin
            div_q <= div_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux

    always_comb
    begin
        rbyte = 8'h00;
        if (hit(req.paddr, `SLTCR_IDX_SER_POL))
        begin
            rbyte[`SLTCR_BIT_SER_POL]   = ser_pol_q;
            rbyte[`SLTCR_BIT_LOOP1_INV] = loop1_inv_q;
            rbyte[`SLTCR_BIT_LOOP2_INV] = loop2_inv_q;
        end
        else if (hit(req.paddr, `SLTCR_IDX_ASYNC_SER))
        begin
            rbyte[`SLTCR_BIT_ASYNC_SER] = async_q;
        end
        else if (hit(req.paddr, `SLTCR_IDX_LINK_RST))
        begin
            rbyte[`SLTCR_BIT_FORCE_RST] = force_rst_q[page_q];
            rbyte[`SLTCR_BIT_DIG_RST]   = dig_rst_q[page_q];
        end
        else if (hit(req.paddr, `SLTCR_IDX_MODE_CHECK))
        begin
            rbyte[`SLTCR_BIT_BAD_MODE] = BAD_MODE_IN[page_q];
        end
        else if (hit(req.paddr, `SLTCR_IDX_QS_OVERRIDE))
        begin
            rbyte[`SLTCR_BIT_QS_OVERRIDE] = override_q;
        end
        else if (hit(req.paddr, `SLTCR_IDX_PHASE_STAT))
        begin
            rbyte[`SLTCR_BIT_PHASE] = PHASE_ALIGNED_IN[page_q];
        end
        else if (hit(req.paddr, `SLTCR_IDX_LANE_DIV))
        begin
            rbyte[`SLTCR_DIV_MSB:`SLTCR_DIV_LSB] = div_q;
        end
        else if (hit(req.paddr, `SLTCR_IDX_LINK_PAGE))
        begin
            rbyte[`SLTCR_BIT_PAGE] = page_q;
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (setup && !req.pwrite)
        begin
            rdata_q <= {24'h00_0000, rbyte};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus answer

    assign rsp.pready  = 1'b1;
    assign rsp.pslverr = access & ~mapped(req.paddr);
    assign rsp.prdata  = rdata_q;

    assign PREADY  = rsp.pready;
    assign PSLVERR = rsp.pslverr;
    assign PRDATA  = rsp.prdata;

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign clk_ctrl.serial_clock_polarity = ser_pol_q;
    assign clk_ctrl.loop1_lane_clock_inv  = loop1_inv_q;
    assign clk_ctrl.loop2_link_clock_inv  = loop2_inv_q;

    assign LINK_RESET     = force_rst_q;
    assign LINK_DIG_RESET = dig_rst_q;
    assign ASYNC_SER_MODE = async_q;
    assign LANE_DIV_SEL   = div_q;
    assign PLL_DIV_MIRROR = div_q;
    assign FRAME_VAL      = frame_q;

    ////////////////////////////////////////////////////////////////////////////
    // clock paths

    sltcr_clk_path u_clk_path
    (
        .clk            (CORE_CLK),
        .rst            (RESET),
        .ctrl           (clk_ctrl),
        .div_sel        (div_q),
        .ser_clk        (SER_CLK_IN),
        .lane_clk       (LANE_CLK_IN),
        .link_clk       (LINK_CLK_IN),
        .ser_clk_dout   (SER_CLK_DOUT),
        .lane_clk_loop1 (LANE_CLK_LOOP1),
        .link_clk_loop2 (LINK_CLK_LOOP2),
        .rate_strobe    (LANE_RATE_STROBE)
    );

endmodule

// ### testbench/sltcr_regs_asserts.sv
`timescale 1ns/1ps
`include "sltcr_cfg.svh"

module sltcr_regs_asserts
#(
    parameter int FRAME_W = 16
)
(
    // clock and reset
    input wire logic               CORE_CLK,
    input wire logic               RESET,
    // apb
    input wire logic               PSEL,
    input wire logic               PENABLE,
    input wire logic               PWRITE,
    input wire logic [15:0]        PADDR,
    input wire logic [31:0]        PWDATA,
    input wire logic [31:0]        PRDATA,
    // divider mirror
    input wire logic               PLL_DIV_WE,
    input wire logic [1:0]         PLL_DIV_WDATA,
    input wire logic [1:0]         PLL_DIV_MIRROR,
    input wire logic [1:0]         LANE_DIV_SEL,
    input wire logic               LANE_RATE_STROBE,
    // frame values
    input wire logic [FRAME_W-1:0] PROG_FRAME_VAL,
    input wire logic [FRAME_W-1:0] FRAME_VAL,
    // link controls
    input wire logic [1:0]         LINK_RESET,
    input wire logic [1:0]         LINK_DIG_RESET,
    input wire logic               ASYNC_SER_MODE,
    input wire logic               SER_CLK_IN,
    input wire logic               SER_CLK_DOUT
);

////////////////////////////////////////////////////////////////////////////////

logic page_q;

// shadow of the link page select
always_ff @(posedge CORE_CLK or posedge RESET)
begin
    if (RESET)
        page_q <= 1'h0;
    else if (PSEL && PENABLE && PWRITE && PADDR == 16'(`SLTCR_IDX_LINK_PAGE * 4))
        page_q <= PWDATA[0];
end

////////////////////////////////////////////////////////////////////////////////

default clocking cb @(posedge CORE_CLK);
endclocking
default disable iff (RESET);

sequence s_wr(logic [15:0] idx);
    PSEL && PENABLE && PWRITE && PADDR == 16'(idx * 4);
endsequence

AST_RST_VAL: assert property ($fell(RESET) |-> LINK_RESET == 2'h3 && LANE_DIV_SEL == 2'h2
    && LINK_DIG_RESET == 2'h0) else $error("reset values wrong");
AST_SER_POL: assert property (s_wr(`SLTCR_IDX_SER_POL) |=>
    (SER_CLK_DOUT ^ SER_CLK_IN) == $past(PWDATA[0])) else $error("serial clock polarity wrong");
AST_ASYNC: assert property (s_wr(`SLTCR_IDX_ASYNC_SER) |=>
    ASYNC_SER_MODE == $past(PWDATA[0])) else $error("async bit not stored");
AST_DIG_RST: assert property (s_wr(`SLTCR_IDX_LINK_RST) |=>
    LINK_DIG_RESET[page_q] == $past(PWDATA[4])) else $error("digital reset wrong link");
AST_FRC_RST: assert property (s_wr(`SLTCR_IDX_LINK_RST) |=>
    LINK_RESET[page_q] == $past(PWDATA[0])) else $error("forced reset wrong link");
AST_FRAME: assert property (s_wr(`SLTCR_IDX_QS_OVERRIDE) ##0 PWDATA[0] |=> ##1
    FRAME_VAL == $past(PROG_FRAME_VAL)) else $error("override frame value not used");
AST_DIV_WR: assert property (s_wr(`SLTCR_IDX_LANE_DIV) |=>
    LANE_DIV_SEL == $past(PWDATA[1:0])) else $error("divider write lost");
AST_STROBE0: assert property (LANE_DIV_SEL == 2'h0 [*3] |-> LANE_RATE_STROBE)
    else $error("undivided strobe missing");
AST_MIRROR: assert property (PLL_DIV_MIRROR == LANE_DIV_SEL)
    else $error("divider mirror differs");
AST_PLL_WR: assert property (PLL_DIV_WE && !(PSEL && PENABLE && PWRITE
    && PADDR == 16'(`SLTCR_IDX_LANE_DIV * 4)) |=> LANE_DIV_SEL == $past(PLL_DIV_WDATA))
    else $error("pll side divider write lost");
AST_RSVD: assert property (PRDATA[31:8] == 24'h0)
    else $error("upper read data not zero");

endmodule

// ### testbench/test_serial_link_tx_control_regs.sv
`timescale 1ns/1ps
`include "sltcr_cfg.svh"

module test_serial_link_tx_control_regs;

localparam int FRAME_W = 16;

logic               CORE_CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, PLL_DIV_WE;
logic [15:0]        PADDR;
logic [31:0]        PWDATA, PRDATA, rd_q;
logic [1:0]         PLL_DIV_WDATA, PLL_DIV_MIRROR, BAD_MODE_IN, PHASE_ALIGNED_IN;
logic [1:0]         LINK_RESET, LINK_DIG_RESET, LANE_DIV_SEL;
logic [FRAME_W-1:0] QS_FRAME_VAL, PROG_FRAME_VAL, FRAME_VAL;
logic               ASYNC_SER_MODE, SER_CLK_DOUT, LANE_CLK_LOOP1, LINK_CLK_LOOP2;
logic               LANE_RATE_STROBE, err_q;
logic [2:0]         clk_cnt;
logic [7:0]         pol_tab [4];
int                 n_errors, tests_run, cycles, n_strobe;

sltcr_regs #(.FRAME_W(FRAME_W)) dut (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
    .PLL_DIV_WE(PLL_DIV_WE), .PLL_DIV_WDATA(PLL_DIV_WDATA), .PLL_DIV_MIRROR(PLL_DIV_MIRROR),
    .BAD_MODE_IN(BAD_MODE_IN), .PHASE_ALIGNED_IN(PHASE_ALIGNED_IN),
    .QS_FRAME_VAL(QS_FRAME_VAL), .PROG_FRAME_VAL(PROG_FRAME_VAL), .FRAME_VAL(FRAME_VAL),
    .LINK_RESET(LINK_RESET), .LINK_DIG_RESET(LINK_DIG_RESET), .ASYNC_SER_MODE(ASYNC_SER_MODE),
    .LANE_DIV_SEL(LANE_DIV_SEL), .SER_CLK_IN(clk_cnt[0]), .LANE_CLK_IN(clk_cnt[1]),
    .LINK_CLK_IN(clk_cnt[2]), .SER_CLK_DOUT(SER_CLK_DOUT), .LANE_CLK_LOOP1(LANE_CLK_LOOP1),
    .LINK_CLK_LOOP2(LINK_CLK_LOOP2), .LANE_RATE_STROBE(LANE_RATE_STROBE)
);

////////////////////////////////////////////////////////////////////////////////

initial
begin
    CORE_CLK = 1'h0;
    forever #20 CORE_CLK = ~CORE_CLK;
end

// toggling clock inputs and hang guard
always @(posedge CORE_CLK)
begin
    clk_cnt <= clk_cnt + 3'h1;
    cycles  <= cycles + 1;
    if (cycles == 3000)
    begin
        n_errors = n_errors + 1;
        final_report();
    end
end

////////////////////////////////////////////////////////////////////////////////

task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask

task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge CORE_CLK);
    PSEL    <= 1'h1;
    PWRITE  <= wr;
    PADDR   <= 16'(idx * 4);
    PWDATA  <= {24'hFFFFFF, wd};
    @(posedge CORE_CLK);
    PENABLE <= 1'h1;
    do
        @(posedge CORE_CLK);
    while (PREADY !== 1'h1);
    rd_q    = PRDATA;
    err_q   = PSLVERR;
    PSEL    <= 1'h0;
    PENABLE <= 1'h0;
endtask

task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    apb(1'h1, idx, wd);
endtask

task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'h0, idx, 8'h00);
    check(rd_q, {24'h0, exp});
endtask

task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask

////////////////////////////////////////////////////////////////////////////////

initial
begin
    {PSEL, PENABLE, PWRITE, PLL_DIV_WE, PADDR, PWDATA, PLL_DIV_WDATA} = '0;
    {n_errors, tests_run, cycles, clk_cnt} = '0;
    BAD_MODE_IN      = 2'h2;
    PHASE_ALIGNED_IN = 2'h1;
    QS_FRAME_VAL     = 16'h1111;
    PROG_FRAME_VAL   = 16'h2222;
    pol_tab          = '{8'h01, 8'h10, 8'h20, 8'hFF};
    RESET            = 1'h1;
    repeat (3) @(posedge CORE_CLK);
    RESET <= 1'h0;
    @(negedge CORE_CLK);
    check(32'({LINK_RESET, LINK_DIG_RESET, LANE_DIV_SEL}), 32'h32);
    rd(`SLTCR_IDX_SER_POL, 8'h00);
    rd(`SLTCR_IDX_ASYNC_SER, 8'h00);
    rd(`SLTCR_IDX_LINK_RST, 8'h01);
    rd(`SLTCR_IDX_QS_OVERRIDE, 8'h00);
    rd(`SLTCR_IDX_LANE_DIV, 8'h02);
    $display("test reset_values done");
    for (int i = 0; i < 4; i++)
    begin
        wr(`SLTCR_IDX_SER_POL, pol_tab[i]);
        rd(`SLTCR_IDX_SER_POL, pol_tab[i] & 8'h31);
        @(negedge CORE_CLK);
        check(32'({SER_CLK_DOUT, LANE_CLK_LOOP1, LINK_CLK_LOOP2}),
            32'({clk_cnt[0], clk_cnt[1], clk_cnt[2]}
                ^ {pol_tab[i][0], pol_tab[i][5], pol_tab[i][4]}));
    end
    $display("test polarity done");
    wr(`SLTCR_IDX_ASYNC_SER, 8'hFF);
    rd(`SLTCR_IDX_ASYNC_SER, 8'h01);
    check(32'(err_q), 32'h0);
    check(32'(ASYNC_SER_MODE), 32'h1);
    $display("test async done");
    wr(`SLTCR_IDX_LINK_RST, 8'h10);
    @(negedge CORE_CLK);
    check(32'({LINK_RESET, LINK_DIG_RESET}), 32'h9);
    wr(`SLTCR_IDX_LINK_PAGE, 8'h01);
    rd(`SLTCR_IDX_LINK_RST, 8'h01);
    wr(`SLTCR_IDX_LINK_RST, 8'hFE);
    rd(`SLTCR_IDX_LINK_RST, 8'h10);
    check(32'({LINK_RESET, LINK_DIG_RESET}), 32'h3);
    rd(`SLTCR_IDX_MODE_CHECK, 8'h01);
    rd(`SLTCR_IDX_PHASE_STAT, 8'h00);
    wr(`SLTCR_IDX_LINK_PAGE, 8'h00);
    rd(`SLTCR_IDX_LINK_RST, 8'h10);
    rd(`SLTCR_IDX_MODE_CHECK, 8'h00);
    rd(`SLTCR_IDX_PHASE_STAT, 8'h01);
    $display("test link_pages done");
    check(32'(FRAME_VAL), 32'h1111);
    wr(`SLTCR_IDX_QS_OVERRIDE, 8'hFF);
    rd(`SLTCR_IDX_QS_OVERRIDE, 8'h01);
    check(32'(FRAME_VAL), 32'h2222);
    $display("test override done");
    for (int c = 0; c < 4; c++)
    begin
        wr(`SLTCR_IDX_LANE_DIV, 8'hFC | 8'(c));
        rd(`SLTCR_IDX_LANE_DIV, 8'(c));
        check(32'(PLL_DIV_MIRROR), 32'(c));
        n_strobe = 0;
        repeat (16)
        begin
            @(negedge CORE_CLK);
            n_strobe += (LANE_RATE_STROBE === 1'h1) ? 1 : 0;
        end
        check(32'(n_strobe), 32'(16 >> c));
    end
    @(posedge CORE_CLK);
    PLL_DIV_WE    <= 1'h1;
    PLL_DIV_WDATA <= 2'h1;
    @(posedge CORE_CLK);
    PLL_DIV_WE    <= 1'h0;
    rd(`SLTCR_IDX_LANE_DIV, 8'h01);
    $display("test divider done");
    wr(16'h0700, 8'hFF);
    check(32'(err_q), 32'h1);
    rd(16'h0700, 8'h00);
    check(32'(err_q), 32'h1);
    $display("test unmapped done");
    final_report();
end

endmodule

bind sltcr_regs sltcr_regs_asserts #(.FRAME_W(FRAME_W)) u_chk (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PLL_DIV_WE(PLL_DIV_WE),
    .PLL_DIV_WDATA(PLL_DIV_WDATA), .PLL_DIV_MIRROR(PLL_DIV_MIRROR),
    .LANE_DIV_SEL(LANE_DIV_SEL), .LANE_RATE_STROBE(LANE_RATE_STROBE),
    .PROG_FRAME_VAL(PROG_FRAME_VAL), .FRAME_VAL(FRAME_VAL), .LINK_RESET(LINK_RESET),
    .LINK_DIG_RESET(LINK_DIG_RESET), .ASYNC_SER_MODE(ASYNC_SER_MODE),
    .SER_CLK_IN(SER_CLK_IN), .SER_CLK_DOUT(SER_CLK_DOUT)
);
